// ---- rtl/tbpwm_params.svh ----
`ifndef TBPWM_PARAMS_SVH
`define TBPWM_PARAMS_SVH

// register byte addresses on the apb bus
`define TBPWM_OFS_CONTROL 12'h000
`define TBPWM_OFS_DUTY_UPPER 12'h004
`define TBPWM_OFS_DUTY_LOWER 12'h008

// control register field positions
`define TBPWM_CTL_ENABLE_BIT 7
`define TBPWM_CTL_LEVEL_BIT 5
`define TBPWM_CTL_POLARITY_BIT 4

// duty lower register field position (bits 7:6)
`define TBPWM_DUTY_LOW_MSB 7
`define TBPWM_DUTY_LOW_LSB 6

// reset values
`define TBPWM_CONTROL_RESET 1'b0
`define TBPWM_BUFFER_RESET 10'h000

`endif

// ---- rtl/tbpwm_pkg.sv ----
package tbpwm_pkg;

    // signals arriving from the shared period timer, same clock domain
    typedef struct packed {
        logic       clear;
        logic       period_match;
        logic [7:0] count;
        logic [1:0] phase;
    } tbpwm_timer_s;

    typedef logic [9:0] tbpwm_duty_t;

endpackage

// ---- rtl/tbpwm_channel.sv ----
// Functional notes
// - control bit 7 enables the channel
// - control bit 5 reads live output level
// - control bit 4 selects active-low output
// - duty upper register holds duty bits 9:2
// - duty lower bits 7:6 hold duty 1:0
// - unimplemented bits read zero, ignore writes
// - control bits clear on every reset
// - duty registers survive resets, undefined at power-on
// - timer clear sets, duty match clears output
// - duty copied to buffer at period match
// - zero duty keeps output inactive at rollover
// - compare against timer count plus phase bits
//
// Chosen here: the address map and register access over APB.
`include "tbpwm_params.svh"

module tbpwm_channel
    import tbpwm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tbpwm_timer_s timer_in,
    output logic pwm_out
);

    logic channel_enable;
    logic output_polarity_select;
    logic [7:0] duty_value_high_bits;
    logic [1:0] duty_value_low_bits;
    tbpwm_duty_t compare_buffer;
    logic raw_active;
    logic next_channel_enable;
    logic next_output_polarity_select;
    logic [7:0] next_duty_value_high_bits;
    logic [1:0] next_duty_value_low_bits;
    tbpwm_duty_t next_compare_buffer;
    logic next_raw_active;
    logic next_pwm_out;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic access_done;
    logic wr_control;
    logic wr_upper;
    logic wr_lower;
    tbpwm_duty_t time_base;
    tbpwm_duty_t rollover_duty;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        addr_is = (a == ADDR_W'(ofs));
    endfunction

    // a write lands only on the edge where the master sees pready high
    assign access_done = psel & penable & pready;
    assign wr_control = access_done & pwrite & pstrb[0] & addr_is(paddr, `TBPWM_OFS_CONTROL);
    assign wr_upper = access_done & pwrite & pstrb[0] & addr_is(paddr, `TBPWM_OFS_DUTY_UPPER);
    assign wr_lower = access_done & pwrite & pstrb[0] & addr_is(paddr, `TBPWM_OFS_DUTY_LOWER);

    // one wait state: read data is registered on the same edge that raises pready
    always_comb begin
        next_pready = psel & penable & ~pready;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (psel & penable & ~pready) begin
            if (addr_is(paddr, `TBPWM_OFS_CONTROL)) begin
                next_prdata[`TBPWM_CTL_ENABLE_BIT] = channel_enable;
                next_prdata[`TBPWM_CTL_LEVEL_BIT] = pwm_out;
                next_prdata[`TBPWM_CTL_POLARITY_BIT] = output_polarity_select;
            end else if (addr_is(paddr, `TBPWM_OFS_DUTY_UPPER)) begin
                next_prdata[7:0] = duty_value_high_bits;
            end else if (addr_is(paddr, `TBPWM_OFS_DUTY_LOWER)) begin
                next_prdata[`TBPWM_DUTY_LOW_MSB:`TBPWM_DUTY_LOW_LSB] = duty_value_low_bits;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // control bits; level bit is read-only and never stored from a write
    always_comb begin
        next_channel_enable = channel_enable;
        next_output_polarity_select = output_polarity_select;
        if (wr_control) begin
            next_channel_enable = pwdata[`TBPWM_CTL_ENABLE_BIT];
            next_output_polarity_select = pwdata[`TBPWM_CTL_POLARITY_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_enable <= `TBPWM_CONTROL_RESET;
            output_polarity_select <= `TBPWM_CONTROL_RESET;
        end else begin
            channel_enable <= next_channel_enable;
            output_polarity_select <= next_output_polarity_select;
        end
    end

    // duty bits; unused lanes of the lower register are simply dropped
    always_comb begin
        next_duty_value_high_bits = duty_value_high_bits;
        next_duty_value_low_bits = duty_value_low_bits;
        if (wr_upper) begin
            next_duty_value_high_bits = pwdata[7:0];
        end
        if (wr_lower) begin
            next_duty_value_low_bits = pwdata[`TBPWM_DUTY_LOW_MSB:`TBPWM_DUTY_LOW_LSB];
        end
    end

    // no reset here on purpose: contents ride through resets, unknown at power-up
    always_ff @(posedge pclk) begin
        duty_value_high_bits <= next_duty_value_high_bits;
        duty_value_low_bits <= next_duty_value_low_bits;
    end

    // 10-bit time base from the 8-bit count and two phase bits
    assign time_base = {timer_in.count, timer_in.phase};
    // if load and rollover coincide, the freshly latched duty decides
    assign rollover_duty = timer_in.period_match ?
        {duty_value_high_bits, duty_value_low_bits} : compare_buffer;

    // waveform: buffer loads on period match, set on clear, drop on equality
    always_comb begin
        next_compare_buffer = compare_buffer;
        next_raw_active = raw_active;
        if (timer_in.period_match) begin
            next_compare_buffer = {duty_value_high_bits, duty_value_low_bits};
        end
        if (!channel_enable) begin
            next_raw_active = 1'b0;
        end else if (timer_in.clear) begin
            next_raw_active = (rollover_duty != 10'h000);
        end else if (time_base == compare_buffer) begin
            next_raw_active = 1'b0;
        end
        next_pwm_out = next_raw_active ^ next_output_polarity_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_buffer <= `TBPWM_BUFFER_RESET;
            raw_active <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            compare_buffer <= next_compare_buffer;
            raw_active <= next_raw_active;
            pwm_out <= next_pwm_out;
        end
    end

    // checks on the live waveform
    a_disable_holds_off: assert property (@(posedge pclk) disable iff (!presetn)
        !channel_enable |=> !raw_active)
        else $error("raw output active while channel disabled");

    a_pin_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_out == (raw_active ^ output_polarity_select))
        else $error("output pin does not follow polarity select");

    a_clear_sets_out: assert property (@(posedge pclk) disable iff (!presetn)
        channel_enable && timer_in.clear && rollover_duty != 10'h000 |=> raw_active)
        else $error("timer clear did not set output");

    a_zero_duty_idle: assert property (@(posedge pclk) disable iff (!presetn)
        channel_enable && timer_in.clear && rollover_duty == 10'h000 |=> !raw_active)
        else $error("zero duty asserted output at rollover");

    a_match_drops_out: assert property (@(posedge pclk) disable iff (!presetn)
        channel_enable && !timer_in.clear && {timer_in.count, timer_in.phase} ==
        compare_buffer |=> !raw_active)
        else $error("duty match did not clear output");

    a_buffer_loads: assert property (@(posedge pclk) disable iff (!presetn)
        timer_in.period_match |=> compare_buffer ==
        $past({duty_value_high_bits, duty_value_low_bits}))
        else $error("compare buffer not loaded at period match");

    a_buffer_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_in.period_match |=> $stable(compare_buffer))
        else $error("compare buffer changed without period match");

    // checks on the register side
    a_level_readback: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pready) && addr_is(paddr, `TBPWM_OFS_CONTROL) |->
        prdata[`TBPWM_CTL_LEVEL_BIT] == $past(pwm_out))
        else $error("control read does not show output level");

    a_ctrl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        pready && addr_is(paddr, `TBPWM_OFS_CONTROL) |->
        prdata[6] == 1'b0 && prdata[3:0] == 4'h0 && prdata[31:8] == 24'h000000)
        else $error("control reserved bits read nonzero");

    a_lower_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        pready && addr_is(paddr, `TBPWM_OFS_DUTY_LOWER) |->
        prdata[5:0] == 6'h00 && prdata[31:8] == 24'h000000)
        else $error("duty lower reserved bits read nonzero");

    a_upper_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_upper |=> duty_value_high_bits == $past(pwdata[7:0]))
        else $error("duty upper write not stored");

    a_lower_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_lower |=> duty_value_low_bits == $past(pwdata[7:6]))
        else $error("duty lower write not stored");

endmodule

// ---- test/tbpwm_timer_model.sv ----
// shared period timer: phase counts every cycle, count every fourth
module tbpwm_timer_model
    import tbpwm_pkg::*;
#(
    parameter logic [7:0] LIMIT = 8'h09
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output tbpwm_timer_s timer
);
    timeunit 1ns;
    timeprecision 1ps;
    // match is flagged in the last cycle at the limit, clear in the first cycle after rollover
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= '0;
        end else begin
            timer.period_match <= run && timer.count == LIMIT && timer.phase == 2'h2;
            timer.clear <= run && timer.period_match;
            if (run) begin
                timer.phase <= timer.phase + 2'h1;
                if (timer.phase == 2'h3) begin
                    timer.count <= (timer.count == LIMIT) ? 8'h00 : timer.count + 8'h01;
                end
            end
        end
    end
endmodule

// ---- test/tbpwm_channel_bench.sv ----
`include "tbpwm_params.svh"
module tbpwm_channel_bench
    import tbpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'h1BBE7471;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, pwm_out, m_en = 0, m_pol = 0, m_raw = 0;
    logic [7:0] m_hi = '0;
    logic [1:0] m_lo = '0;
    logic [9:0] m_buf = '0, nd, cur, duty;
    logic [9:0] dtab [4] = '{10'h000, 10'h001, 10'h027, 10'h028};
    tbpwm_timer_s timer_in;
    int err_count = 0, total_checks = 0;

    tbpwm_timer_model u_timer (.pclk(pclk), .presetn(presetn), .run(run), .timer(timer_in));
    tbpwm_channel u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_in(timer_in), .pwm_out(pwm_out));

    initial begin
        forever #2 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one apb transfer; model registers follow the write at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; a hung slave is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        // a write with the low byte lane off must leave the registers alone
        if (wr && pslverr === 1'b0 && pstrb[0] === 1'b1) begin
            if (a == `TBPWM_OFS_CONTROL) begin
                m_en <= d[7];
                m_pol <= d[4];
            end
            if (a == `TBPWM_OFS_DUTY_UPPER) m_hi <= d[7:0];
            if (a == `TBPWM_OFS_DUTY_LOWER) m_lo <= d[7:6];
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // reference output: buffer loads at match, clear sets unless duty zero, base match ends pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_raw <= 1'b0;
            m_buf <= '0;
            m_en <= 1'b0;
            m_pol <= 1'b0;
        end else begin
            nd = {m_hi, m_lo};
            cur = timer_in.period_match ? nd : m_buf;
            if (timer_in.period_match) m_buf <= nd;
            if (!m_en) m_raw <= 1'b0;
            else if (timer_in.clear) m_raw <= (cur != 10'h000);
            else if ({timer_in.count, timer_in.phase} == m_buf) m_raw <= 1'b0;
        end
    end

    // pin compared mid-cycle, clear of every edge race
    always @(negedge pclk) begin
        if (presetn) check(pwm_out, m_raw ^ m_pol);
    end

    initial begin
        #100000;
        err_count++;
        complete_run;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`TBPWM_OFS_CONTROL, 32'h0);
        apb(1'b1, `TBPWM_OFS_DUTY_LOWER, 32'hFFFFFFFF);
        rdchk(`TBPWM_OFS_DUTY_LOWER, 32'hC0);
        apb(1'b1, `TBPWM_OFS_DUTY_UPPER, 32'hFFFFFFA5);
        rdchk(`TBPWM_OFS_DUTY_UPPER, 32'hA5);
        pstrb <= 4'hE;
        apb(1'b1, `TBPWM_OFS_DUTY_UPPER, 32'h0000005A);
        pstrb <= 4'hF;
        rdchk(`TBPWM_OFS_DUTY_UPPER, 32'hA5);
        apb(1'b1, `TBPWM_OFS_CONTROL, 32'hFF);
        rdchk(`TBPWM_OFS_CONTROL, 32'hB0);
        rdchk(12'h00C, 32'h0);
        check(er, 32'h1);
        run <= 1'b1;
        // duty writes land at arbitrary points in the period, so buffering is exercised
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            duty = (i < 4) ? dtab[i] : 10'(seed % 48);
            apb(1'b1, `TBPWM_OFS_DUTY_UPPER, {24'h0, duty[9:2]});
            apb(1'b1, `TBPWM_OFS_DUTY_LOWER, {24'h0, duty[1:0], 6'h00});
            apb(1'b1, `TBPWM_OFS_CONTROL, {24'h0, i != 9, 2'b00, seed[4], 4'h0});
            repeat (80) @(posedge pclk);
        end
        run <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`TBPWM_OFS_CONTROL, 32'h0);
        rdchk(`TBPWM_OFS_DUTY_UPPER, {24'h0, m_hi});
        rdchk(`TBPWM_OFS_DUTY_LOWER, {24'h0, m_lo, 6'h00});
        complete_run;
    end
endmodule
